// file: design/mcs_master_clock_selector.sv
// Purpose: Picks the master clock among four sources with glitch-free handover
// Assumes: Source clocks and ready flags are sampled as levels on sys_clk
// Notes:   Master clock output is a registered level built from sampled sources
//          Wake-up counter runs on while its visible copy is frozen by the gate
//          Halt blocks new switches but never touches the selection in force
//
// Notes on behaviour
// - Exactly four sources: crystal, external clock input, fast RC, slow RC.
// - After reset the master clock is the fast RC divided by eight.
// - Every source has an independent enable bit.
// - A switch is accepted only toward a source that reports stable.
// - The wake-up timer counts on its own source, not the master clock.
// - Entering halt leaves the source selection untouched.
`timescale 1ns/1ns
module mcs_master_clock_selector
  import mcs_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire mcs_pkg::mcs_ctrl_t ctrl,
  input  wire logic              halt_req,
  input  wire logic              wakeup_timer_gate,
  input  wire logic [3:0]        src_clk,
  input  wire logic [3:0]        src_ready,
  output logic [3:0]             src_en_out,
  output logic                   master_clk,
  output mcs_pkg::mcs_stat_t     status,
  output logic [31:0]            wakeup_timer_count
);
  import mcs_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [3:0] clk_s, rdy_s;

  mcs_sync #(.W(8)) u_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in ({src_ready, src_clk}),
    .sync_out ({rdy_s, clk_s})
  );

  // ----------------------------------------------------------------
  // Enables and selection state
  // ----------------------------------------------------------------
  logic [3:0] en_r, en_nxt;
  mcs_src_t   cur_r, cur_nxt, tgt_r, tgt_nxt;
  mcs_state_t st_r, st_nxt;
  logic       div8_r, div8_nxt;
  logic       mclk_r, mclk_nxt;
  logic       last_r, last_nxt;
  logic [2:0] dcnt_r, dcnt_nxt;
  logic       busy_r, busy_nxt;
  logic [31:0] wut_r, wut_nxt;
  logic [31:0] view_r, view_nxt;
  logic       last_src_r, last_src_nxt;
  logic       sel_lvl, req_ok;

  // ----------------------------------------------------------------
  // Source pick and request check
  // ----------------------------------------------------------------

  // Current source level, undivided; the optional divide by eight is applied later
  always_comb begin
    sel_lvl = clk_s[cur_r];
  end

  // Switch allowed only to an enabled, stable, different source
  assign req_ok = ctrl.sel_req && !halt_req && en_r[ctrl.sel]
                  && rdy_s[ctrl.sel] && (ctrl.sel != cur_r);

  // ----------------------------------------------------------------
  // Selection state machine and master clock
  // ----------------------------------------------------------------
  // Next state of selection and handover
  always_comb begin
    en_nxt   = ctrl.src_en;
    cur_nxt  = cur_r;
    tgt_nxt  = tgt_r;
    st_nxt   = st_r;
    div8_nxt = div8_r & ~ctrl.div8_off;
    mclk_nxt = mclk_r;
    last_nxt = sel_lvl;
    dcnt_nxt = dcnt_r;
    // Never disable the source currently driving the master clock
    en_nxt[cur_r] = 1'b1;
    if (st_r != MCS_ST_RUN) begin
      en_nxt[tgt_r] = 1'b1;
    end
    unique case (st_r)
      MCS_ST_RUN: begin
        // Idle: latch the target of a request that passes every check
        if (req_ok) begin
          tgt_nxt = ctrl.sel;
          st_nxt  = MCS_ST_OFF;
        end
      end
      MCS_ST_OFF: begin
        // Wait for old clock low so the high phase is never cut
        if (!mclk_r) begin
          st_nxt = MCS_ST_ON;
        end
      end
      MCS_ST_ON: begin
        // Hand over while the new source sits low, still stable
        // Target lost its stable flag: give up, the old source stays
        if (!rdy_s[tgt_r]) begin
          st_nxt = MCS_ST_RUN;
        end else if (!clk_s[tgt_r]) begin
          cur_nxt  = tgt_r;
          div8_nxt = 1'b0;
          dcnt_nxt = '0;
          st_nxt   = MCS_ST_RUN;
        end
      end
      default: st_nxt = MCS_ST_RUN;
    endcase

    // Master clock generation, held low during handover. In divide-by-eight
    // mode the output toggles on every fourth sampled rising edge of the
    // source, so one master period spans eight source periods.
    if (st_r == MCS_ST_RUN) begin
      if (div8_r) begin
        if (sel_lvl && !last_r) begin
          if (dcnt_r == MCS_DIV_LAST) begin
            dcnt_nxt = '0;
            mclk_nxt = ~mclk_r;
          end else begin
            dcnt_nxt = dcnt_r + 3'h1;
          end
        end
      end else begin
        mclk_nxt = sel_lvl;
      end
    end else if (st_r == MCS_ST_OFF && div8_r) begin
      // Divider runs on so a high phase already begun keeps its full length
      if (mclk_r && sel_lvl && !last_r) begin
        if (dcnt_r == MCS_DIV_LAST) begin
          dcnt_nxt = '0;
          mclk_nxt = 1'b0;
        end else begin
          dcnt_nxt = dcnt_r + 3'h1;
        end
      end
    end else if (st_r == MCS_ST_OFF) begin
      // Undivided source: follow it down, never raise again
      mclk_nxt = sel_lvl & mclk_r;
    end else begin
      mclk_nxt = 1'b0;
    end
    // Busy flag registered so the status port comes from a flip-flop
    busy_nxt = (st_nxt != MCS_ST_RUN);
  end

  // ----------------------------------------------------------------
  // Wake-up timer
  // ----------------------------------------------------------------
  // Counter runs on sampled slow RC edges whatever the gate does;
  // the gate stands for a stopped register clock and freezes only the copy
  always_comb begin
    wut_nxt      = wut_r;
    last_src_nxt = clk_s[MCS_SRC_SRC];
    view_nxt     = view_r;
    if (clk_s[MCS_SRC_SRC] && !last_src_r) begin
      wut_nxt = wut_r + 32'h0000_0001;
    end
    // Visible copy catches up as soon as the register clock returns
    if (!wakeup_timer_gate) begin
      view_nxt = wut_r;
    end
  end

  // Timer registers, kept apart from the selection logic
  // so that nothing tied to the master clock can stall the count
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wut_r      <= MCS_WUT_RST;
      last_src_r <= 1'b0;
      view_r     <= MCS_WUT_RST;
    end else begin
      wut_r      <= wut_nxt;
      last_src_r <= last_src_nxt;
      view_r     <= view_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Selection registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_r       <= MCS_RST_EN;
      cur_r      <= MCS_RST_SRC;
      tgt_r      <= MCS_RST_SRC;
      st_r       <= MCS_ST_RUN;
      div8_r     <= MCS_RST_DIV8;
      mclk_r     <= 1'b0;
      last_r     <= 1'b0;
      dcnt_r     <= '0;
      busy_r     <= 1'b0;
    end else begin
      en_r       <= en_nxt;
      cur_r      <= cur_nxt;
      tgt_r      <= tgt_nxt;
      st_r       <= st_nxt;
      div8_r     <= div8_nxt;
      mclk_r     <= mclk_nxt;
      last_r     <= last_nxt;
      dcnt_r     <= dcnt_nxt;
      busy_r     <= busy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Status and outputs straight from flip-flops
  assign src_en_out                 = en_r;
  assign master_clk                 = mclk_r;
  assign status.src_stable          = rdy_s;
  assign status.master_clock_status = cur_r;
  assign status.switch_busy         = busy_r;
  assign status.div8_on             = div8_r;
  assign wakeup_timer_count         = view_r;
endmodule : mcs_master_clock_selector

// file: design/mcs_pkg.sv
// Purpose: Shared constants and types for the master clock selector
// Assumes: sys_clk at 125 MHz; source clocks arrive as sampled levels
// Notes:   Source codes and reset values live here only
package mcs_pkg;

  // ----------------------------------------------------------------
  // Source selection codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MCS_SRC_XTAL = 2'h0,
    MCS_SRC_EXT  = 2'h1,
    MCS_SRC_FRC  = 2'h2,
    MCS_SRC_SRC  = 2'h3
  } mcs_src_t;

  localparam int       MCS_NUM_SRC      = 4;
  localparam mcs_src_t MCS_RST_SRC      = MCS_SRC_FRC;
  localparam logic [3:0] MCS_RST_EN     = 4'h4;
  localparam logic     MCS_RST_DIV8     = 1'b1;
  localparam int       MCS_DIV8_HALF    = 4;
  localparam logic [2:0] MCS_DIV_LAST   = 3'h3;
  localparam logic [31:0] MCS_WUT_RST   = 32'h0000_0000;

  // Switch handshake states
  typedef enum logic [1:0] {
    MCS_ST_RUN  = 2'h0,
    MCS_ST_OFF  = 2'h1,
    MCS_ST_ON   = 2'h2
  } mcs_state_t;

  // Software control bundle
  typedef struct packed {
    logic [3:0] src_en;
    mcs_src_t   sel;
    logic       sel_req;
    logic       div8_off;
  } mcs_ctrl_t;

  // Status bundle
  typedef struct packed {
    logic [3:0] src_stable;
    mcs_src_t   master_clock_status;
    logic       switch_busy;
    logic       div8_on;
  } mcs_stat_t;

endpackage : mcs_pkg

// file: design/mcs_sync.sv
// Purpose: Three-stage synchroniser with agreement filter, one per bit
// Assumes: Inputs are asynchronous to sys_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module mcs_sync #(
  parameter int W = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_r, s2_r, s3_r, out_r;
  logic [W-1:0] out_nxt;

  // Output follows once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_comb begin
        out_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : out_r[g];
      end
    end
  endgenerate

  // Register stages
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end else begin
      s1_r  <= async_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;
endmodule : mcs_sync

// file: tb/mcs_assertions.sv
// Purpose: Port checks for the master clock selector
// Assumes: One clock domain, async low reset
// Notes:   Bound to every selector instance
`timescale 1ns/1ns
module mcs_checker
  import mcs_pkg::*;
(
  input logic               sys_clk,
  input logic               rst_b,
  input mcs_pkg::mcs_ctrl_t ctrl,
  input logic               halt_req,
  input logic               wakeup_timer_gate,
  input logic [3:0]         src_en_out,
  input mcs_pkg::mcs_stat_t status,
  input logic [31:0]        wakeup_timer_count
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_rst_src;
    $rose(rst_b) |-> status.master_clock_status == MCS_SRC_FRC && status.div8_on;
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("bad start source");
  property p_cur_en;
    1'b1 |-> src_en_out[status.master_clock_status];
  endproperty
  a_cur_en: assert property (p_cur_en) else $error("current source off");
  property p_take;
    ctrl.sel_req && !halt_req && src_en_out[ctrl.sel] && status.src_stable[ctrl.sel]
      && ctrl.sel != status.master_clock_status && !status.switch_busy |=> status.switch_busy;
  endproperty
  a_take: assert property (p_take) else $error("switch not taken");
  property p_refuse;
    ctrl.sel_req && !status.switch_busy && !status.src_stable[ctrl.sel] |=> !status.switch_busy;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unstable target taken");
  property p_halt;
    halt_req && !status.switch_busy |=> !status.switch_busy;
  endproperty
  a_halt: assert property (p_halt) else $error("switch during halt");
  property p_chg;
    $changed(status.master_clock_status) |-> $past(status.switch_busy);
  endproperty
  a_chg: assert property (p_chg) else $error("source changed unasked");
  property p_done;
    $rose(status.switch_busy) |-> ##[1:300] !status.switch_busy;
  endproperty
  a_done: assert property (p_done) else $error("switch hangs");
  property p_gate;
    wakeup_timer_gate && $past(wakeup_timer_gate) |=> $stable(wakeup_timer_count);
  endproperty
  a_gate: assert property (p_gate) else $error("gated timer moved");
  c_switch: cover property ($fell(status.switch_busy));
  c_halt: cover property (halt_req && ctrl.sel_req);
  c_gate: cover property (wakeup_timer_gate);
  c_div8: cover property ($fell(status.div8_on));
endmodule : mcs_checker

bind mcs_master_clock_selector mcs_checker mcs_checker_i (.sys_clk, .rst_b, .ctrl, .halt_req,
  .wakeup_timer_gate, .src_en_out, .status, .wakeup_timer_count);

// file: tb/tb.sv
// Purpose: Self-checking bench for the master clock selector
// Assumes: Source clocks made from a free counter
// Notes:   Fast RC rises every 4 cycles
`timescale 1ns/1ns
module tb;
  import mcs_pkg::*;
  logic       sys_clk, rst_b, halt_req, wakeup_timer_gate, master_clk;
  logic [3:0] src_clk, src_ready, src_en_out;
  logic [4:0] cnt;
  logic [31:0] wakeup_timer_count, c;
  mcs_ctrl_t  ctrl;
  mcs_stat_t  status;
  int         mismatches, total_checks;
  time        t;
  mcs_master_clock_selector mcs_master_clock_selector_i (.sys_clk, .rst_b, .ctrl, .halt_req,
    .wakeup_timer_gate, .src_clk, .src_ready, .src_en_out, .master_clk, .status,
    .wakeup_timer_count);
  // ------------------------------------------------------------
  // Clock and sources
  // ------------------------------------------------------------
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cnt <= cnt + 5'h01;
    src_clk <= {cnt[4], cnt[1], cnt[2], cnt[3]};
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Request a switch and check the source in force afterwards
  task automatic sw(mcs_src_t s, logic [3:0] en, logic [3:0] rdy, logic h, mcs_src_t e);
    @(posedge sys_clk);
    ctrl.src_en <= en;
    src_ready <= rdy;
    halt_req <= h;
    repeat (6) @(posedge sys_clk);
    ctrl.sel <= s;
    ctrl.sel_req <= 1'b1;
    repeat (2) @(posedge sys_clk);
    ctrl.sel_req <= 1'b0;
    #1;
    for (int i = 0; i < 300 && status.switch_busy !== 1'b0; i++) @(posedge sys_clk) #1;
    chk("src", 32'(e), 32'(status.master_clock_status));
  endtask : sw
  task automatic summarize;
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    #400000;
    mismatches++;
    summarize();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    cnt = 0; src_clk = 0; src_ready = 4'h4; halt_req = 0; wakeup_timer_gate = 0;
    ctrl = '{src_en: 4'h4, sel: MCS_SRC_FRC, sel_req: 1'b0, div8_off: 1'b0};
    rst_b = 0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 chk("en", 32'h4, 32'(src_en_out));
    chk("div8", 32'h1, 32'(status.div8_on));
    chk("src", 32'(MCS_SRC_FRC), 32'(status.master_clock_status));
    repeat (3) @(posedge master_clk);
    t = $time;
    @(posedge master_clk);
    chk("period", 32'h0000_0100, 32'($time - t));
    sw(MCS_SRC_XTAL, 4'hF, 4'h4, 1'b0, MCS_SRC_FRC);
    chk("stable", 32'h4, 32'(status.src_stable));
    sw(MCS_SRC_XTAL, 4'h4, 4'hF, 1'b0, MCS_SRC_FRC);
    sw(MCS_SRC_XTAL, 4'hF, 4'hF, 1'b1, MCS_SRC_FRC);
    sw(MCS_SRC_XTAL, 4'hF, 4'hF, 1'b0, MCS_SRC_XTAL);
    sw(MCS_SRC_EXT, 4'hF, 4'hF, 1'b0, MCS_SRC_EXT);
    sw(MCS_SRC_SRC, 4'hF, 4'hF, 1'b0, MCS_SRC_SRC);
    sw(MCS_SRC_FRC, 4'hF, 4'hF, 1'b0, MCS_SRC_FRC);
    chk("div8", 32'h0, 32'(status.div8_on));
    sw(MCS_SRC_FRC, 4'h9, 4'hF, 1'b0, MCS_SRC_FRC);
    chk("en", 32'hD, 32'(src_en_out));
    @(posedge sys_clk) wakeup_timer_gate <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 c = wakeup_timer_count;
    repeat (80) @(posedge sys_clk);
    #1 chk("wut", c, wakeup_timer_count);
    @(posedge sys_clk) wakeup_timer_gate <= 1'b0;
    @(posedge sys_clk);
    #1 chk("wut_run", 32'h1, 32'((wakeup_timer_count - c) >= 32'h2));
    @(posedge sys_clk) rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 chk("wut_rst", MCS_WUT_RST, wakeup_timer_count);
    chk("div8", 32'h1, 32'(status.div8_on));
    @(posedge sys_clk) ctrl.div8_off <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk("div8_off", 32'h0, 32'(status.div8_on));
    repeat (3) @(posedge master_clk);
    t = $time;
    @(posedge master_clk);
    chk("period", 32'h0000_0020, 32'($time - t));
    summarize();
  end
endmodule : tb
